// file: src/dedc_top.sv
// Behaviour
// R1: nine event sources; four maskable, two of the five unmasked ones disable the stream
// R2: event enters queue only when its status bit set and mask allows
// R3: status words kept oldest first in a 32 entry circular queue
// R4: stream index and event bits always valid; hit bits, offset conditional
// R5: queue status shows pending, write and read pointers; port read pops
// R6: software checks queue status and never reads the port when empty
// R7: interrupt line high while any status word is queued
// R8: full queue drops new events and sets overflow until a pop
// R9: arrival overflow on wait limit exceeded or write meets read pointer
// R10: arrival overflow keeps stream, aborts packet, flushes write buffer
// R11: internal reset returns to idle; buffered packet start proceeds at once
// R12: arrival overflow skips config write back, queues arrival status word
// R13: destination stop reached disables stream, flushes, saves, queues overrun
// R14: bad section on pointer mismatch, continuity error, or non FF stuffing
// R15: stream continuity checked only with error pattern; never queued
// R16: linear incrementing mode counts up from low field, ignoring limits
// R17: linear fixed mode writes every item to high and low address
// R18: non-incremental mode steps only address bits one and zero
// R19: 27 MHz counters; reference registers load at every new packet
// R20: PCR flag latches sample and 8 bytes; held until upper read
// R21: decoder latch rising edge loads stamp; rearms after register read
// R22: 20-bit counter stamp refreshed at every packet start
//
// Purpose: event queue, DMA address and clock recovery back end
// Assumes: packet engine presents events and bytes as one-cycle strobes
// Notes:   27 MHz rate comes from a fractional enable divider
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module dedc_top
	import dedc_pkg::*;
#(
	parameter int        QDEPTH   = 32,
	parameter int        QAW      = 5,
	parameter logic [7:0] ARR_WAIT = ARRIVAL_WAIT_DEF
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [11:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Packet engine events
	input  wire logic        pkt_start_i,
	input  wire logic        pkt_proc_i,
	input  wire logic        arr_byte_i,
	input  wire logic        arr_ptr_meet_i,
	input  wire logic [4:0]  stream_i,
	input  wire logic [8:0]  event_i,
	input  wire logic        target_hit_i,
	input  wire logic        second_hit_i,
	input  wire logic [3:0]  filt_offs_i,
	// Section checking
	input  wire logic        sec_stream_i,
	input  wire logic        sec_active_i,
	input  wire logic        unit_start_flag_i,
	input  wire logic [7:0]  sec_ptr_i,
	input  wire logic [7:0]  sec_remain_i,
	input  wire logic        cc_err_i,
	input  wire logic        stuff_valid_i,
	input  wire logic [7:0]  stuff_byte_i,
	// Destination DMA
	input  wire logic        dma_load_i,
	input  wire logic [31:0] dma_init_i,
	input  wire logic [31:0] dma_stop_i,
	input  wire logic        dma_access_i,
	output logic      [31:0] dma_addr_o,
	output logic             flush_o,
	output logic             save_conf3_o,
	output logic             stream_dis_o,
	output logic             internal_rst_o,
	output logic             err_pattern_o,
	// Adaptation field capture
	input  wire logic        af_byte_valid_i,
	input  wire logic [7:0]  af_byte_i,
	input  wire logic        af_first_i,
	// Decoder latches (pins)
	input  wire logic        video_latch_i,
	input  wire logic        audio_latch_i,
	// Interrupt and output-port stamp
	output logic             irq_o,
	output logic      [19:0] out_stamp_o
);
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Registers written by software
	logic [8:0]  mask;
	logic [2:0]  ctrl;
	logic [31:0] stream_en;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mask <= MASK_RESET;
			ctrl <= 3'h0;
		end else if (wr_i && addr_i == REG_MASK) begin
			mask <= wdata_i[8:0];
		end else if (wr_i && addr_i == REG_CTRL) begin
			ctrl <= wdata_i[2:0];
		end
	end

	// Section checks and continuity handling
	logic bad_sec;
	always_comb begin
		bad_sec = 1'b0;
		if (sec_stream_i && sec_active_i) begin
			// R14 section error cases
			if (unit_start_flag_i && sec_ptr_i != sec_remain_i) begin
				bad_sec = 1'b1;
			end
			if (cc_err_i) begin
				bad_sec = 1'b1;
			end
			if (!unit_start_flag_i && stuff_valid_i
				&& stuff_byte_i != STUFF_BYTE) begin
				bad_sec = 1'b1;
			end
		end
	end
	// R15 PES continuity, pattern only
	assign err_pattern_o = !sec_stream_i && cc_err_i && ctrl[CT_ERRP_BIT];

	// Arrival wait counter
	logic [7:0]  wait_cnt;
	logic        waiting;
	logic        arr_ovf;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt <= 8'h00;
			waiting  <= 1'b0;
		end else if (pkt_proc_i || arr_ovf) begin
			waiting  <= pkt_start_i && !pkt_proc_i;
			wait_cnt <= 8'h00;
		end else if (pkt_start_i) begin
			waiting  <= 1'b1;
			wait_cnt <= 8'h00;
		end else if (waiting && arr_byte_i) begin
			wait_cnt <= wait_cnt + 8'h01;
		end
	end
	// R9 two overflow causes
	assign arr_ovf = (waiting && wait_cnt >= ARR_WAIT) || arr_ptr_meet_i;

	// Destination address and overrun
	logic        dst_ovr;
	logic [31:0] next_addr;
	assign dst_ovr = dma_access_i && dma_addr_o == dma_stop_i
		&& !ctrl[CT_LINEAR_BIT];
	always_comb begin
		next_addr = dma_addr_o;
		if (ctrl[CT_LINEAR_BIT]) begin
			// R16 linear increment
			if (ctrl[CT_INCR_BIT]) begin
				next_addr = dma_addr_o + 32'h1;
			end
			// R17 fixed address otherwise
		end else if (!ctrl[CT_INCR_BIT]) begin
			// R18 low two bits only
			next_addr[1:0] = dma_addr_o[1:0] + 2'h1;
		end else begin
			next_addr = dma_addr_o + 32'h1;
		end
	end
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			dma_addr_o <= 32'h0;
		end else if (dma_load_i) begin
			dma_addr_o <= dma_init_i;
		end else if (dma_access_i && !dst_ovr) begin
			dma_addr_o <= next_addr;
		end
	end

	// Packet state: drop after overrun; arrival overflow returns to idle or next packet
	dedc_state_t state;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state <= DEDC_IDLE;
		end else begin
			case (state)
				DEDC_IDLE: if (pkt_proc_i) begin
					state <= DEDC_PKT;
				end
				DEDC_PKT: if (arr_ovf) begin
					// R11 back to awaiting, or straight on
					state <= pkt_start_i ? DEDC_PKT : DEDC_IDLE;
				end else if (dst_ovr) begin
					state <= DEDC_DROP;
				end
				DEDC_DROP: if (pkt_start_i) begin
					state <= DEDC_IDLE;
				end
				default: state <= DEDC_IDLE;
			endcase
		end
	end

	// Effects of error events
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			flush_o        <= 1'b0;
			save_conf3_o   <= 1'b0;
			stream_dis_o   <= 1'b0;
			internal_rst_o <= 1'b0;
		end else begin
			// R10 abort and flush, stream kept
			// R13 overrun flushes and saves
			flush_o        <= arr_ovf || dst_ovr;
			// R12 no write back on arrival overflow
			save_conf3_o   <= dst_ovr && !arr_ovf;
			// R1 only two events disable
			stream_dis_o   <= dst_ovr || bad_sec;
			internal_rst_o <= arr_ovf;
		end
	end

	// Per-stream enable bits, cleared by the disabling events
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stream_en <= 32'h0;
		end else if (dst_ovr || bad_sec) begin
			stream_en[stream_i] <= 1'b0;
		end else if (wr_i && addr_i == REG_STREAM_EN) begin
			stream_en <= wdata_i;
		end
	end

	// Status word assembly
	logic [8:0]  ev_all;
	logic [8:0]  ev_gate;
	logic        ev_push;
	logic [31:0] status_word;
	always_comb begin
		ev_all = event_i;
		ev_all[EV_ARR_OVF] = arr_ovf;
		ev_all[EV_DST_OVR] = dst_ovr;
		ev_all[EV_BAD_SEC] = bad_sec;
	end
	// R1 R2 maskable sources need mask set
	assign ev_gate = ev_all & (UNMASKED_SET | (mask & MASKABLE_SET));
	assign ev_push = |ev_gate;
	always_comb begin
		// R4 conditional fields zero when invalid
		status_word = 32'h0;
		status_word[NUM_EVENTS-1:0] = ev_gate;
		status_word[SW_STREAM_LSB +: 5] = stream_i;
		if (ev_gate[EV_FILT_DON] || ev_gate[EV_PART_FLT]) begin
			status_word[SW_TARGET_BIT] = target_hit_i;
			status_word[SW_SECOND_BIT] = second_hit_i;
		end
		if (ev_gate[EV_PART_FLT]) begin
			status_word[SW_OFFS_LSB +: 4] = filt_offs_i;
		end
	end

	// Event queue
	logic [QAW:0]  wp;
	logic [QAW:0]  rp;
	logic          q_empty;
	logic          q_full;
	logic          q_ovf;
	logic          pop;
	logic          push;
	logic [31:0]   q_rdata;
	assign q_empty = wp == rp;
	assign q_full  = wp[QAW] != rp[QAW] && wp[QAW-1:0] == rp[QAW-1:0];
	// R6 pop of an empty queue is ignored
	assign pop  = rd_i && addr_i == REG_QUEUE_WORD && !q_empty;
	assign push = ev_push && !q_full;

	// R3 R5 pointers advance per write and read
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wp <= '0;
			rp <= '0;
		end else begin
			if (push) begin
				wp <= wp + 1'b1;
			end
			if (pop) begin
				rp <= rp + 1'b1;
			end
		end
	end
	// R8 overflow flag; a new overflow wins over the clear
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			q_ovf <= 1'b0;
		end else if (ev_push && q_full) begin
			q_ovf <= 1'b1;
		end else if (pop) begin
			q_ovf <= 1'b0;
		end
	end
	// R7 level interrupt while not empty
	assign irq_o = !q_empty;

	dedc_queue_mem #(
		.DEPTH(QDEPTH),
		.WIDTH(32),
		.AW   (QAW)
	) u_mem (
		.ref_clk_i(ref_clk_i),
		.wr_en_i  (push),
		.wr_addr_i(wp[QAW-1:0]),
		.wr_data_i(status_word),
		.rd_addr_i(rp[QAW-1:0]),
		.rd_data_o(q_rdata)
	);

	// 27 MHz enable from a phase accumulator
	logic [7:0] acc;
	logic       tick27;
	assign tick27 = acc + ACC_STEP >= ACC_WRAP;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc <= 8'h00;
		end else if (tick27) begin
			acc <= acc + ACC_STEP - ACC_WRAP;
		end else begin
			acc <= acc + ACC_STEP;
		end
	end

	// R19 local counters at 27 MHz; R22 20-bit stamp counter
	logic [8:0]  ext_cnt;
	logic [31:0] base_cnt;
	logic [19:0] stamp_cnt;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_cnt   <= 9'h000;
			base_cnt  <= 32'h0;
			stamp_cnt <= 20'h00000;
		end else if (tick27) begin
			ext_cnt   <= ext_cnt + 9'h001;
			base_cnt  <= base_cnt + 32'h1;
			stamp_cnt <= stamp_cnt + 20'h00001;
		end
	end
	logic [8:0]  ref_ext;
	logic [31:0] ref_base;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ref_ext     <= 9'h000;
			ref_base    <= 32'h0;
			out_stamp_o <= 20'h00000;
		end else if (pkt_start_i) begin
			// R19 load at packet; R22 refresh stamp
			ref_ext     <= ext_cnt;
			ref_base    <= base_cnt;
			out_stamp_o <= stamp_cnt;
		end
	end

	// R20 adaptation capture, locked until upper read
	logic [63:0] adapt_cap;
	logic [2:0]  af_idx;
	logic        af_busy;
	logic        af_lock;
	logic [31:0] pcr_sample;
	logic        upper_rd;
	assign upper_rd = rd_i && addr_i == REG_ADAPT_UP;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			adapt_cap  <= 64'h0;
			af_idx     <= 3'h0;
			af_busy    <= 1'b0;
			af_lock    <= 1'b0;
			pcr_sample <= 32'h0;
		end else begin
			if (af_byte_valid_i && af_first_i && !af_lock
				&& (af_byte_i & PCR_FLAG) != 8'h00) begin
				pcr_sample    <= base_cnt;
				adapt_cap[7:0] <= af_byte_i;
				af_idx        <= 3'h1;
				af_busy       <= 1'b1;
				af_lock       <= 1'b1;
			end else if (af_byte_valid_i && af_busy) begin
				adapt_cap[{af_idx, 3'h0} +: 8] <= af_byte_i;
				af_idx  <= af_idx + 3'h1;
				af_busy <= af_idx != 3'(ADAPT_BYTES - 1);
			end else if (upper_rd && !af_busy) begin
				af_lock <= 1'b0;
			end
		end
	end

	// R21 decoder latch edges, two-flop synchronised
	logic [2:0]  vsync;
	logic [2:0]  async_;
	logic [31:0] vstamp;
	logic [31:0] astamp;
	logic        varm;
	logic        aarm;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			vsync  <= 3'h0;
			async_ <= 3'h0;
			vstamp <= 32'h0;
			astamp <= 32'h0;
			varm   <= 1'b1;
			aarm   <= 1'b1;
		end else begin
			vsync  <= {vsync[1:0], video_latch_i};
			async_ <= {async_[1:0], audio_latch_i};
			if (varm && vsync[1] && !vsync[2]) begin
				vstamp <= base_cnt;
				varm   <= 1'b0;
			end else if (rd_i && addr_i == REG_VIDEO_STAMP) begin
				varm <= 1'b1;
			end
			if (aarm && async_[1] && !async_[2]) begin
				astamp <= base_cnt;
				aarm   <= 1'b0;
			end else if (rd_i && addr_i == REG_AUDIO_STAMP) begin
				aarm <= 1'b1;
			end
		end
	end

	// Read data, one cycle after the strobe
	logic [11:0] rd_addr_q;
	logic        rd_q;
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_addr_q <= 12'h000;
			rd_q      <= 1'b0;
		end else begin
			rd_addr_q <= addr_i;
			rd_q      <= rd_i;
		end
	end
	always_comb begin
		rdata_o = 32'h0;
		if (rd_q) begin
			case (rd_addr_q)
				REG_QUEUE_STAT: begin
					rdata_o[QS_PEND_BIT] = !q_empty;
					rdata_o[QS_OVF_BIT]  = q_ovf;
					rdata_o[QS_WP_LSB +: QAW+1] = wp;
					rdata_o[QS_RP_LSB +: QAW+1] = rp;
				end
				REG_QUEUE_WORD:  rdata_o = q_rdata;
				REG_MASK:        rdata_o[8:0] = mask;
				REG_CTRL:        rdata_o[2:0] = ctrl;
				REG_REF_EXT:     rdata_o[8:0] = ref_ext;
				REG_REF_BASE:    rdata_o = ref_base;
				REG_ADAPT_LOW:   rdata_o = adapt_cap[31:0];
				REG_ADAPT_UP:    rdata_o = adapt_cap[63:32];
				REG_VIDEO_STAMP: rdata_o = vstamp;
				REG_AUDIO_STAMP: rdata_o = astamp;
				REG_DMA_ADDR:    rdata_o = dma_addr_o;
				REG_OUT_STAMP:   rdata_o[19:0] = out_stamp_o;
				REG_STREAM_EN:   rdata_o = stream_en;
				default:         rdata_o = 32'h0;
			endcase
		end
	end

	// a_irq_level: a stored word raises the line
	a_irq_level: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		push |=> irq_o) else $error("irq not raised on push"); // R7
	a_push_ptr: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		push |=> wp == $past(wp) + 1'b1) else $error("wp stuck"); // R5
	a_full_ovf: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(ev_push && q_full) |=> q_ovf && wp == $past(wp))
		else $error("overflow not flagged"); // R8
	a_pop_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(pop && !(ev_push && q_full)) |=> !q_ovf)
		else $error("overflow not cleared"); // R8
	a_mask_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(event_i[EV_FILT_DON] && !mask[EV_FILT_DON])
		|-> !ev_gate[EV_FILT_DON])
		else $error("masked event passed"); // R2
	a_arr_keep: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(arr_ovf && !dst_ovr && !bad_sec) |=> flush_o && !save_conf3_o
		&& !stream_dis_o) else $error("arrival overflow effects"); // R10
	a_ovr_dis: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		(dst_ovr && !arr_ovf) |=> stream_dis_o && save_conf3_o)
		else $error("overrun effects"); // R13
	sequence s_vedge;
		!vsync[2] && vsync[1] && varm;
	endsequence
	a_vstamp_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		s_vedge |=> vstamp == $past(base_cnt) && !varm)
		else $error("video stamp not loaded"); // R21
	a_ref_load: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
		pkt_start_i |=> ref_base == $past(base_cnt))
		else $error("reference not loaded"); // R19
endmodule

// file: src/dedc_pkg.sv
// Purpose: constants shared by the demux event, DMA and clock unit
// Assumes: 32-bit register port, byte offsets
// Notes:   status word and register layouts live here
package dedc_pkg;
	// Register byte offsets
	localparam logic [11:0] REG_QUEUE_STAT  = 12'h000;
	localparam logic [11:0] REG_QUEUE_WORD  = 12'h004;
	localparam logic [11:0] REG_MASK        = 12'h008;
	localparam logic [11:0] REG_CTRL        = 12'h00C;
	localparam logic [11:0] REG_REF_EXT     = 12'h010;
	localparam logic [11:0] REG_REF_BASE    = 12'h014;
	localparam logic [11:0] REG_ADAPT_LOW   = 12'h018;
	localparam logic [11:0] REG_ADAPT_UP    = 12'h01C;
	localparam logic [11:0] REG_VIDEO_STAMP = 12'h020;
	localparam logic [11:0] REG_AUDIO_STAMP = 12'h024;
	localparam logic [11:0] REG_DMA_ADDR    = 12'h028;
	localparam logic [11:0] REG_OUT_STAMP   = 12'h02C;
	localparam logic [11:0] REG_STREAM_EN   = 12'h030;
	// Event bit positions in the status word
	localparam int EV_ARR_OVF  = 0;
	localparam int EV_DST_OVR  = 1;
	localparam int EV_BAD_SEC  = 2;
	localparam int EV_FILT_DON = 3;
	localparam int EV_SEC_DON  = 4;
	localparam int EV_PART_FLT = 5;
	localparam int EV_ADAPT    = 6;
	localparam int EV_OUT_UND  = 7;
	localparam int EV_OUT_OVF  = 8;
	localparam int NUM_EVENTS  = 9;
	localparam logic [8:0] MASKABLE_SET = 9'h078;
	localparam logic [8:0] UNMASKED_SET = 9'h187;
	localparam logic [8:0] DISABLE_SET  = 9'h006;
	localparam logic [8:0] MASK_RESET   = 9'h000;
	// Status word fields
	localparam int SW_STREAM_LSB = 16;
	localparam int SW_TARGET_BIT = 10;
	localparam int SW_SECOND_BIT = 11;
	localparam int SW_OFFS_LSB   = 12;
	// Queue status fields
	localparam int QS_PEND_BIT = 0;
	localparam int QS_OVF_BIT  = 1;
	localparam int QS_WP_LSB   = 8;
	localparam int QS_RP_LSB   = 16;
	// Control register fields
	localparam int CT_LINEAR_BIT = 0;
	localparam int CT_INCR_BIT   = 1;
	localparam int CT_ERRP_BIT   = 2;
	localparam logic [7:0] ARRIVAL_WAIT_DEF = 8'hBC;
	localparam logic [7:0] STUFF_BYTE = 8'hFF;
	localparam logic [7:0] PCR_FLAG = 8'h10;
	localparam int ADAPT_BYTES = 8;
	// Divider from 125 MHz to the 27 MHz video rate (phase accumulator)
	localparam int CLK_MHZ   = 125;
	localparam int VIDEO_MHZ = 27;
	localparam logic [7:0] ACC_STEP = 8'(VIDEO_MHZ);
	localparam logic [7:0] ACC_WRAP = 8'(CLK_MHZ);
	typedef enum logic [1:0] {
		DEDC_IDLE = 2'b00,
		DEDC_PKT  = 2'b01,
		DEDC_DROP = 2'b10
	} dedc_state_t;
endpackage

// file: src/dedc_queue_mem.sv
// Purpose: status word storage for the event queue
// Assumes: one write and one read port, same clock
// Notes:   read data registered
`timescale 1ns/1ps
module dedc_queue_mem #(
	parameter int DEPTH = 32,
	parameter int WIDTH = 32,
	parameter int AW    = 5
) (
	// Clock
	input  wire logic             ref_clk_i,
	// Write side
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	// Read side
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// file: test/dedc_host_model.sv
// Purpose: CPU side model driving the register port
// Assumes: one strobe per access, read data the cycle after
// Notes:   pops a status word only after seeing it pending
`timescale 1ns/1ps
module dedc_host_model
	import dedc_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Register port
	input  wire logic [31:0] rdata_i,
	output logic      [11:0] addr_o,
	output logic      [31:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	initial begin
		addr_o = 12'h000;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask
	task automatic pop(output logic got, output logic [31:0] w);
		logic [31:0] s;
		got = 1'b0;
		w = 32'h0;
		for (int i = 0; i < 8 && !got; i++) begin
			rd(REG_QUEUE_STAT, s);
			got = s[QS_PEND_BIT];
		end
		if (got)
			rd(REG_QUEUE_WORD, w);
	endtask
endmodule

// file: test/tb_demux_event_dma_clock_unit.sv
// Purpose: self-checking bench for the event queue and DMA back end
// Assumes: arrival wait limit shortened to 4 bytes
// Notes:   pulse outputs are counted on the falling edge
`timescale 1ns/1ps
module tb_demux_event_dma_clock_unit;
	import dedc_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, d, v1, dma_addr;
	logic wr, rd, flush, save3, sdis, irst, errp, irq;
	logic ps = 0, pp = 0, ab = 0, pm = 0, usf = 0, cc = 0, sv = 0;
	logic sst = 0, sac = 0, ld = 0, acc = 0, afv = 0, aff = 0;
	logic vid = 0, aud = 0, got, th = 0, sh = 0;
	logic [3:0] fo = 4'h0;
	logic [4:0] strm = 5'h00;
	logic [8:0] ev = 9'h000, g;
	logic [7:0] sb = 8'h00, afb = 8'h00, spt = 8'h00;
	logic [31:0] di = 32'h0, ds = 32'h0;
	logic [19:0] ost, o1;
	int mismatches = 0, check_count = 0, p = 0;
	int n_fl, n_sv, n_ds, n_ir;
	logic [8:0] rm [7] = '{9'h000, 9'h008, 9'h010, 9'h040,
		9'h000, 9'h000, 9'h1FF};
	logic [8:0] re [7] = '{9'h008, 9'h008, 9'h020, 9'h040,
		9'h080, 9'h100, 9'h020};
	logic [1:0] dc [3] = '{2'h3, 2'h1, 2'h0};
	logic [31:0] dx [3] = '{32'h0000_1003, 32'h0000_2000, 32'h0000_3002};
	logic [31:0] dy [3] = '{32'h0000_1000, 32'h0000_2000, 32'h0000_3003};
	logic [31:0] dz [3] = '{32'h0000_1001, 32'h0000_2000, 32'hFFFF_FFF0};

	initial begin
		forever #4 clk = ~clk;
	end
	dedc_host_model HOST (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	dedc_top #(.ARR_WAIT(8'h04)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .pkt_start_i(ps), .pkt_proc_i(pp),
		.arr_byte_i(ab), .arr_ptr_meet_i(pm), .stream_i(strm),
		.event_i(ev), .target_hit_i(th), .second_hit_i(sh),
		.filt_offs_i(fo), .sec_stream_i(sst), .sec_active_i(sac),
		.unit_start_flag_i(usf), .sec_ptr_i(spt),
		.sec_remain_i(8'h00), .cc_err_i(cc), .stuff_valid_i(sv),
		.stuff_byte_i(sb), .dma_load_i(ld), .dma_init_i(di),
		.dma_stop_i(ds), .dma_access_i(acc), .dma_addr_o(dma_addr),
		.flush_o(flush), .save_conf3_o(save3), .stream_dis_o(sdis),
		.internal_rst_o(irst), .err_pattern_o(errp),
		.af_byte_valid_i(afv), .af_byte_i(afb), .af_first_i(aff),
		.video_latch_i(vid), .audio_latch_i(aud), .irq_o(irq),
		.out_stamp_o(ost));

	// Falling edge keeps counting clear of the bench's own updates
	always @(negedge clk) begin
		n_fl += int'(flush);
		n_sv += int'(save3);
		n_ds += int'(sdis);
		n_ir += int'(irst);
	end
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic xw(input logic xg, input logic [4:0] s,
		input logic [8:0] b);
		logic gg;
		logic [31:0] w;
		HOST.pop(gg, w);
		chk("word_seen", {31'h0, gg}, {31'h0, xg});
		if (gg)
			chk("word", w, {11'h0, s, 7'h0, b});
		p += int'(gg);
	endtask
	task automatic clr;
		n_fl = 0;
		n_sv = 0;
		n_ds = 0;
		n_ir = 0;
	endtask
	task automatic af(input logic [7:0] b);
		for (int i = 0; i < ADAPT_BYTES; i++) begin
			@(posedge clk);
			afv <= 1'b1;
			aff <= (i == 0);
			afb <= b;
		end
		@(posedge clk);
		afv <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#300000;
		mismatches++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		HOST.rd(REG_QUEUE_STAT, d);
		chk("qstat_rst", d, 32'h0);
		chk("irq_rst", {31'h0, irq}, 32'h0);
		HOST.rd(REG_MASK, d);
		chk("mask_rst", d, {23'h0, MASK_RESET});
		HOST.rd(12'h034, d);
		chk("unmapped", d, 32'h0);
		for (int i = 0; i < 7; i++) begin
			HOST.wr(REG_MASK, {23'h0, rm[i]});
			@(posedge clk);
			ev <= re[i];
			strm <= 5'(i + 3);
			@(posedge clk);
			ev <= 9'h000;
			g = re[i] & (rm[i] | UNMASKED_SET);
			xw(|g, 5'(i + 3), g);
		end
		// Hit bits for filter events, offset for partial filter only
		th <= 1'b1;
		sh <= 1'b1;
		fo <= 4'hA;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			ev <= i ? 9'h008 : 9'h020;
			strm <= 5'h11;
			@(posedge clk);
			ev <= 9'h000;
			HOST.pop(got, d);
			chk("word_extras", d, {11'h0, 5'h11, i ? 4'h0 : 4'hA,
				2'h3, 1'h0, i ? 9'h008 : 9'h020});
			p += int'(got);
		end
		th <= 1'b0;
		sh <= 1'b0;
		fo <= 4'h0;
		HOST.wr(REG_MASK, 32'h0);
		for (int i = 0; i < 33; i++) begin
			@(posedge clk);
			ev <= 9'h080;
			strm <= 5'(i);
		end
		@(posedge clk);
		ev <= 9'h000;
		HOST.rd(REG_QUEUE_STAT, d);
		chk("qstat_full", d, {10'h0, 6'(p), 2'h0, 6'(p + 32), 8'h03});
		for (int i = 0; i < 32; i++) begin
			chk("irq_held", {31'h0, irq}, 32'h1);
			xw(1'b1, 5'(i), 9'h080);
			if (i == 0) begin
				HOST.rd(REG_QUEUE_STAT, d);
				chk("ovf_clear", {31'h0, d[QS_OVF_BIT]}, 32'h0);
			end
		end
		chk("irq_empty", {31'h0, irq}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			HOST.wr(REG_CTRL, {30'h0, dc[i]});
			@(posedge clk);
			ld <= 1'b1;
			di <= dy[i];
			ds <= dz[i];
			@(posedge clk);
			ld <= 1'b0;
			acc <= 1'b1;
			repeat (3) @(posedge clk);
			acc <= 1'b0;
			@(posedge clk);
			chk("dma_addr", dma_addr, dx[i]);
			xw(1'b0, 5'h00, 9'h000);
		end
		// Stop equal to start: the first access overruns
		HOST.wr(REG_CTRL, 32'h2);
		clr();
		@(posedge clk);
		ld <= 1'b1;
		di <= 32'h0000_4000;
		ds <= 32'h0000_4000;
		strm <= 5'h1F;
		@(posedge clk);
		ld <= 1'b0;
		acc <= 1'b1;
		@(posedge clk);
		acc <= 1'b0;
		xw(1'b1, 5'h1F, 9'h002);
		chk("ovr_pulses", {n_fl[7:0], n_sv[7:0], n_ds[7:0]}, 32'h010101);
		clr();
		strm <= 5'h0A;
		@(posedge clk);
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		ab <= 1'b1;
		repeat (3) @(posedge clk);
		ab <= 1'b0;
		xw(1'b0, 5'h0A, 9'h000);
		@(posedge clk);
		ab <= 1'b1;
		@(posedge clk);
		ab <= 1'b0;
		xw(1'b1, 5'h0A, 9'h001);
		chk("arr_pulses", {n_fl[7:0], n_sv[7:0], n_ds[7:0], n_ir[7:0]},
			32'h01000001);
		@(posedge clk);
		pm <= 1'b1;
		@(posedge clk);
		pm <= 1'b0;
		xw(1'b1, 5'h0A, 9'h001);
		clr();
		@(posedge clk);
		sst <= 1'b1;
		sac <= 1'b1;
		cc <= 1'b1;
		@(posedge clk);
		cc <= 1'b0;
		xw(1'b1, 5'h0A, 9'h004);
		chk("bad_dis", n_ds, 32'h1);
		@(posedge clk);
		usf <= 1'b1;
		spt <= 8'h03;
		@(posedge clk);
		usf <= 1'b0;
		spt <= 8'h00;
		xw(1'b1, 5'h0A, 9'h004);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			sv <= 1'b1;
			sb <= i ? STUFF_BYTE : 8'h00;
			@(posedge clk);
			sv <= 1'b0;
			xw(i == 0, 5'h0A, 9'h004);
		end
		HOST.wr(REG_CTRL, 32'h4);
		@(posedge clk);
		sst <= 1'b0;
		sac <= 1'b0;
		cc <= 1'b1;
		#1 chk("err_patt", {31'h0, errp}, 32'h1);
		@(posedge clk);
		cc <= 1'b0;
		xw(1'b0, 5'h0A, 9'h000);
		af(8'h10);
		af(8'h30);
		HOST.rd(REG_ADAPT_LOW, d);
		chk("af_held", d, 32'h1010_1010);
		HOST.rd(REG_ADAPT_UP, d);
		af(8'h30);
		HOST.rd(REG_ADAPT_LOW, d);
		chk("af_new", d, 32'h3030_3030);
		@(posedge clk);
		vid <= 1'b1;
		repeat (4) @(posedge clk);
		HOST.rd(REG_VIDEO_STAMP, v1);
		vid <= 1'b0;
		repeat (20) @(posedge clk);
		vid <= 1'b1;
		repeat (4) @(posedge clk);
		HOST.rd(REG_VIDEO_STAMP, d);
		chk("vstamp_moved", {31'h0, d !== v1}, 32'h1);
		HOST.rd(REG_REF_BASE, v1);
		o1 = ost;
		@(posedge clk);
		ps <= 1'b1;
		@(posedge clk);
		ps <= 1'b0;
		pp <= 1'b1;
		@(posedge clk);
		pp <= 1'b0;
		HOST.rd(REG_REF_BASE, d);
		chk("ref_moved", {31'h0, d !== v1}, 32'h1);
		chk("ostamp_moved", {31'h0, ost !== o1}, 32'h1);
		give_verdict();
	end
endmodule
